// [src/bspt_pkg.sv]
// package: modes, control fields and timing constants for the backplane port timing block
package bspt_pkg;

  // port generation
  typedef enum logic [0:0] {
    BSPT_GEN_ONE = 1'b0,
    BSPT_GEN_TWO = 1'b1
  } bspt_gen_t;

  // application of the access
  typedef enum logic [1:0] {
    BSPT_APP_LTS = 2'b00,
    BSPT_APP_LTT = 2'b01,
    BSPT_APP_NT  = 2'b10,
    BSPT_APP_TE  = 2'b11
  } bspt_app_t;

  // serial port control word as written by the host
  typedef struct packed {
    logic       timing_mode;   // first generation: 0 clock, 1 delayed sync
    logic       strobe1_b2;    // first generation te: frame_sync_one marks b2
    logic       strobe2_b2;    // first generation te: frame_sync_two marks b2
    logic [1:0] data_strobe_two_slot_a;   // data_strobe_two first slot (b1,b2,ic1,ic2)
    logic [1:0] data_strobe_two_slot_b;   // data_strobe_two second slot
    logic       data_strobe_two_two;      // data_strobe_two uses both slots
  } bspt_ctrl_t;

  // pin group driven by the block
  typedef struct packed {
    logic shared_clk;          // serial_clock_port_a / frame_sync_delayed / strobe / bit clock
    logic fsync1_o;
    logic fsync1_oe_n;
    logic fsync2_o;
    logic fsync2_oe_n;
    logic dcl_o;
    logic dcl_oe_n;
    logic rst_o;
    logic rst_oe_n;
  } bspt_pins_t;

  localparam bspt_ctrl_t BSPT_CTRL_RESET = '0;

  // timing
  localparam int BSPT_SYS_KHZ = 250000;
  localparam int BSPT_SSI_CLK_KHZ = 128;
  localparam int BSPT_TE_BCL_KHZ = 768;
  localparam int BSPT_TE_DCL_KHZ = 1536;
  localparam int BSPT_RST_MIN_DCL = 4;
  localparam int BSPT_RST_OUT_MS = 4;
  localparam int BSPT_RST_OUT_CYC = BSPT_RST_OUT_MS * BSPT_SYS_KHZ;
  // half periods in system cycles (longest times round down)
  localparam int BSPT_SSI_HALF = BSPT_SYS_KHZ / (2 * BSPT_SSI_CLK_KHZ);
  localparam int BSPT_DCL_HALF = BSPT_SYS_KHZ / (2 * BSPT_TE_DCL_KHZ);
  // frame layout in data clock periods
  localparam int BSPT_G1_FRAME_DCL = 64;   // 32 bits per 125 us frame at 512 kHz
  localparam int BSPT_G2_FRAME_DCL = 192;  // te: 96 bits per frame at 1536 kHz
  localparam int BSPT_SLOT_DCL = 16;       // one 8 bit channel
endpackage

// [src/bspt_divider.sv]
// divider: one-cycle enable pulse every div cycles
`timescale 1ns/1ps
module bspt_divider #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [WIDTH-1:0] div,
  output logic tick
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic tick_next;

  initial begin
    if (WIDTH < 2) $error("bspt_divider: width too small");
  end

  // wrap at div-1, held at zero while stopped
  assign tick_next = run && (cnt_reg >= div - WIDTH'(1));
  assign cnt_next = (!run || tick_next) ? '0 : cnt_reg + WIDTH'(1);

  // counter and registered tick
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick <= tick_next;
    end
  end
endmodule // bspt_divider

// [src/bspt_timing.sv]
// backplane serial port timing: clocks, frame syncs and strobes
`timescale 1ns/1ps
module bspt_timing #(
  parameter int RST_OUT_CYC = bspt_pkg::BSPT_RST_OUT_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire bspt_pkg::bspt_gen_t gen,
  input wire bspt_pkg::bspt_app_t app,
  input wire logic ctrl_we,
  input wire bspt_pkg::bspt_ctrl_t ctrl_wdata,
  input wire logic te_func_en,
  input wire logic rst_req,
  input wire logic dcl_i,
  input wire logic fsync1_i,
  input wire logic fsync2_i,
  input wire logic rst_i,
  output bspt_pkg::bspt_pins_t pins,
  output logic frame_start,
  output logic port_reset
);
  localparam int FW = 8;

  initial begin
    if (RST_OUT_CYC < 1) $error("bspt_timing: reset pulse length too small");
  end

  // two-flop synchronisers for pin inputs
  // every pin is async to clk_sys; the link clock is slow against it, so the
  // two cycles of extra latency only shift edges and never lose one
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  wire dcl_s = sync2_reg[0];
  wire fs1_s = sync2_reg[1];
  wire fs2_s = sync2_reg[2];
  wire rst_s = sync2_reg[3];
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {rst_i, fsync2_i, fsync1_i, dcl_i};
      sync2_reg <= sync1_reg;
    end
  end

  // mode decoding
  wire te = (app == bspt_pkg::BSPT_APP_TE);
  wire g2 = (gen == bspt_pkg::BSPT_GEN_TWO);

  // control register, written by the host
  // a write during port reset is dropped: the clear must win over the host
  bspt_pkg::bspt_ctrl_t ctrl_reg;
  logic written_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= bspt_pkg::BSPT_CTRL_RESET;
      written_reg <= 1'b0;
    end else if (port_reset) begin
      ctrl_reg <= bspt_pkg::BSPT_CTRL_RESET;
      written_reg <= 1'b0;
    end else if (ctrl_we) begin
      ctrl_reg <= ctrl_wdata;
      written_reg <= 1'b1;
    end
  end

  // data clock edge detect on the synced pin
  // a pin already high at reset release reads as one early edge; harmless,
  // the frame position realigns on the next far sync
  logic dcl_d_reg;
  wire dcl_rise = dcl_s && !dcl_d_reg;
  // reset out pulse timer for terminal functions
  logic [31:0] rst_out_reg;
  wire rst_out_act = (rst_out_reg != 32'h0);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dcl_d_reg <= 1'b0;
      rst_out_reg <= 32'h0;
      port_reset <= 1'b0;
    end else begin
      dcl_d_reg <= dcl_s;
      // any high level resets; the four-period minimum is on the driver
      port_reset <= rst_s;
      if (te_func_en && rst_req && !rst_out_act)
        rst_out_reg <= 32'(RST_OUT_CYC);
      else if (rst_out_act)
        rst_out_reg <= rst_out_reg - 32'h1;
    end
  end

  // local data clock for te: 1536 kHz, twice the 768 kHz bit clock
  logic dcl_tick;
  logic dcl_loc_reg;
  bspt_divider #(.WIDTH(16)) u_dcl_div (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .run(te),
    .div(16'(bspt_pkg::BSPT_DCL_HALF)),
    .tick(dcl_tick)
  );

  // first generation serial clock at 128 kHz
  // tick period is div cycles; the toggle below halves the rate again
  logic ssi_tick;
  logic ssi_clk_reg;
  bspt_divider #(.WIDTH(16)) u_ssi_div (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .run(!g2),
    .div(16'(bspt_pkg::BSPT_SSI_HALF)),
    .tick(ssi_tick)
  );

  // data clock edges: own clock in te, pin clock otherwise
  wire dcl_edge = te ? (dcl_tick && !dcl_loc_reg) : dcl_rise;
  // frame counter in data clock periods; restarts on external sync
  // te keeps its own frame; network modes obey the far side's sync
  logic [FW-1:0] pos_reg;
  logic fs_d_reg;
  wire [FW-1:0] frame_len = g2 ? FW'(bspt_pkg::BSPT_G2_FRAME_DCL)
                               : FW'(bspt_pkg::BSPT_G1_FRAME_DCL);
  wire ext_fs = fs1_s || fs2_s;
  wire ext_fs_rise = !te && ext_fs && !fs_d_reg;
  wire [FW-1:0] pos_next = ext_fs_rise ? '0 :
    (pos_reg >= frame_len - FW'(1)) ? '0 : pos_reg + FW'(1);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dcl_loc_reg <= 1'b0;
      ssi_clk_reg <= 1'b0;
      pos_reg <= '0;
      fs_d_reg <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      fs_d_reg <= ext_fs;
      if (dcl_tick)
        dcl_loc_reg <= !dcl_loc_reg;
      if (ssi_tick)
        ssi_clk_reg <= !ssi_clk_reg;
      if (dcl_edge || ext_fs_rise)
        pos_reg <= pos_next;
      // pulse only when the position enters zero; an aligned sync lands on an
      // already wrapped frame and must not give a second pulse
      frame_start <= (dcl_edge || ext_fs_rise) && (pos_next == '0) && (pos_reg != '0);
    end
  end

  // slot decoding: 16 data clocks per 8 bit channel
  function automatic logic in_slot(input logic [FW-1:0] p, input logic [1:0] s);
    logic [FW-1:0] base;
    base = FW'(s) * FW'(bspt_pkg::BSPT_SLOT_DCL);
    // slot order b1, b2, two channels skipped from monitor on, ic1, ic2 in gen two
    if (s[1])
      base = base + FW'(2 * bspt_pkg::BSPT_SLOT_DCL);
    in_slot = (p >= base) && (p < base + FW'(bspt_pkg::BSPT_SLOT_DCL));
  endfunction

  wire b1_slot = in_slot(pos_reg, 2'h0);
  wire b2_slot = in_slot(pos_reg, 2'h1);
  wire data_strobe_two = in_slot(pos_reg, ctrl_reg.data_strobe_two_slot_a) ||
              (ctrl_reg.data_strobe_two_two && in_slot(pos_reg, ctrl_reg.data_strobe_two_slot_b));
  // delayed sync: high during the second eighth of the frame
  wire frame_sync_delayed = (pos_reg >= FW'(bspt_pkg::BSPT_G1_FRAME_DCL / 8)) &&
             (pos_reg < FW'(bspt_pkg::BSPT_G1_FRAME_DCL / 4));

  // bit clock for te gen two, toggled in the pin process below
  logic bcl_reg;
  wire dcl_edge_half = bcl_reg;
  // shared clock pin selection
  wire shared_g1 = ctrl_reg.timing_mode ? frame_sync_delayed : ssi_clk_reg;
  wire shared_g2 = te ? dcl_edge_half : data_strobe_two;
  wire shared_sel = written_reg && (g2 ? shared_g2 : shared_g1);
  // frame sync outputs in te
  // gen two te sync spans channels 0 and 1, two slots of 16 data clocks each
  wire fs1_val = g2 ? (pos_reg < FW'(2 * bspt_pkg::BSPT_SLOT_DCL))
                    : (ctrl_reg.strobe1_b2 ? b2_slot : b1_slot);
  wire fs2_val = ctrl_reg.strobe2_b2 ? b2_slot : b1_slot;

  // registered pin drivers; enables are active low while driving
  // enables are registered too, so a pin and its enable switch on one edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bcl_reg <= 1'b0;
      pins <= '{shared_clk: 1'b0, fsync1_o: 1'b0, fsync1_oe_n: 1'b1,
                fsync2_o: 1'b0, fsync2_oe_n: 1'b1, dcl_o: 1'b0, dcl_oe_n: 1'b1,
                rst_o: 1'b0, rst_oe_n: 1'b1};
    end else begin
      // bit clock toggles on each data clock rising edge: half its rate
      if (dcl_edge)
        bcl_reg <= !bcl_reg;
      pins.shared_clk <= shared_sel;
      pins.fsync1_o <= te && written_reg && fs1_val;
      pins.fsync1_oe_n <= !te;
      pins.fsync2_o <= te && !g2 && written_reg && fs2_val;
      pins.fsync2_oe_n <= !(te && !g2);
      pins.dcl_o <= dcl_loc_reg;
      pins.dcl_oe_n <= !te;
      pins.rst_o <= rst_out_act;
      pins.rst_oe_n <= !rst_out_act;
    end
  end
endmodule // bspt_timing

// [sim/bspt_timing_chk.sv]
// checker: pin relations of the port timing block
`timescale 1ns/1ps
module bspt_timing_chk #(
  parameter int RST_OUT_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire bspt_pkg::bspt_gen_t gen,
  input wire bspt_pkg::bspt_app_t app,
  input wire logic ctrl_we,
  input wire logic te_func_en,
  input wire logic rst_i,
  input wire bspt_pkg::bspt_pins_t pins,
  input wire logic port_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire te = app == bspt_pkg::BSPT_APP_TE; // terminal application
  wire g2 = gen == bspt_pkg::BSPT_GEN_TWO; // second generation
  logic pr_d_reg; // port reset one cycle ago
  // delayed copy kept in clocked code so run stays a plain net
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pr_d_reg <= 1'b0;
    else pr_d_reg <= port_reset;
  end
  wire run = te && !port_reset && !pr_d_reg; // settled terminal mode
  logic wr_reg; // host wrote since reset
  // writes in port reset are refused, so they leave the flag low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) wr_reg <= 1'b0;
    else if (port_reset) wr_reg <= 1'b0;
    else if (ctrl_we) wr_reg <= 1'b1;
  end
  property p_idle; !wr_reg && !$past(wr_reg) && !$past(wr_reg, 2) |-> !pins.shared_clk; endproperty
  a_idle: assert property (p_idle) else $error("shared output active before write");
  property p_fs1_in; !te |-> pins.fsync1_oe_n; endproperty
  a_fs1_in: assert property (p_fs1_in) else $error("sync one driven in network mode");
  property p_fs2_in; !te |-> pins.fsync2_oe_n; endproperty
  a_fs2_in: assert property (p_fs2_in) else $error("sync two driven in network mode");
  property p_dcl_in; !te |-> pins.dcl_oe_n; endproperty
  a_dcl_in: assert property (p_dcl_in) else $error("data clock driven in network mode");
  property p_fs1_te; run |=> !pins.fsync1_oe_n; endproperty
  a_fs1_te: assert property (p_fs1_te) else $error("sync one not driven in te");
  property p_fs2_te; run |=> pins.fsync2_oe_n == g2; endproperty
  a_fs2_te: assert property (p_fs2_te) else $error("sync two drive wrong in te");
  property p_rst_in; rst_i [*4] |-> port_reset; endproperty
  a_rst_in: assert property (p_rst_in) else $error("reset pin not honoured");
  property p_rst_oe; !te_func_en [*2] |-> pins.rst_oe_n; endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("reset driven while disabled");
endmodule // bspt_timing_chk
bind bspt_timing bspt_timing_chk #(.RST_OUT_CYC(RST_OUT_CYC)) i_bspt_timing_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .gen(gen), .app(app), .ctrl_we(ctrl_we),
  .te_func_en(te_func_en), .rst_i(rst_i), .pins(pins), .port_reset(port_reset));

// [sim/bspt_far_model.sv]
// far-side peripheral: free-running data clock and frame sync
`timescale 1ns/1ps
module bspt_far_model (
  input wire bspt_pkg::bspt_gen_t gen,
  input wire logic te,
  output logic double_rate_clock,
  output logic fsync
);
  int pos; // clock periods into the frame
  // clock runs free; position moves on falling edges, clear of the sampled rise
  initial begin
    double_rate_clock = 1'b0;
    pos = 0;
    forever begin
      #32 double_rate_clock = ~double_rate_clock; // two periods per bit
      if (!double_rate_clock)
        pos = (pos + 1) % (gen ? bspt_pkg::BSPT_G2_FRAME_DCL : bspt_pkg::BSPT_G1_FRAME_DCL);
    end
  end
  // sync at position 0 in network modes; in te only the pull-up remains
  assign fsync = te | (pos == 0);
endmodule // bspt_far_model

// [sim/tb_top.sv]
// testbench: mode sweep of the backplane port timing block
`timescale 1ns/1ps
module tb_top;
  localparam int DCLP = 2 * bspt_pkg::BSPT_DCL_HALF; // te data clock period
  localparam int FARP = 16; // far clock period in system cycles
  localparam int RSTC = 20; // shortened reset-out length
  logic clk_sys, arst_n, ctrl_we, te_func_en, rst_req, rst_ext, frame_start, port_reset;
  logic dcl_far, fs_far;
  bspt_pkg::bspt_gen_t gen;
  bspt_pkg::bspt_app_t app;
  bspt_pkg::bspt_ctrl_t wd, c;
  bspt_pkg::bspt_pins_t pins;
  int n_fail, n_compared, n;
  logic [31:0] seed;
  // released pins show the far side's level
  wire dcl_w = pins.dcl_oe_n ? dcl_far : pins.dcl_o;
  wire fs1_w = pins.fsync1_oe_n ? fs_far : pins.fsync1_o;
  wire fs2_w = pins.fsync2_oe_n ? fs_far : pins.fsync2_o;
  wire rst_w = pins.rst_oe_n ? rst_ext : pins.rst_o;
  wire [4:0] mon = {frame_start, !pins.rst_oe_n, pins.fsync2_o, pins.fsync1_o,
    pins.shared_clk};
  bspt_timing #(.RST_OUT_CYC(RSTC)) i_bspt_timing (.clk_sys(clk_sys), .arst_n(arst_n),
    .gen(gen), .app(app), .ctrl_we(ctrl_we), .ctrl_wdata(wd), .te_func_en(te_func_en),
    .rst_req(rst_req), .dcl_i(dcl_w), .fsync1_i(fs1_w), .fsync2_i(fs2_w), .rst_i(rst_w),
    .pins(pins), .frame_start(frame_start), .port_reset(port_reset));
  bspt_far_model i_bspt_far_model (.gen(gen), .te(app == bspt_pkg::BSPT_APP_TE),
    .double_rate_clock(dcl_far), .fsync(fs_far));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  function automatic logic [6:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[6:0];
  endfunction
  // mode pins change only inside reset, then one control write
  task automatic start(bspt_pkg::bspt_gen_t g, bspt_pkg::bspt_app_t a);
    int w;
    // network modes: one far frame passes so the first sync has aligned the frame
    w = (a == bspt_pkg::BSPT_APP_TE) ? 0 : FARP * ((g == bspt_pkg::BSPT_GEN_TWO) ?
      bspt_pkg::BSPT_G2_FRAME_DCL : bspt_pkg::BSPT_G1_FRAME_DCL);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    gen <= g;
    app <= a;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    ctrl_we <= 1'b1;
    wd <= c;
    @(posedge clk_sys);
    ctrl_we <= 1'b0;
    // te: let the first, cut phase of each strobe start before measuring
    repeat (w + 8) @(posedge clk_sys);
  endtask
  // bounded wait on a monitored output, sampled on falling edges
  task automatic wait_at(int b, logic v);
    int k;
    for (k = 0; k < 40000 && mon[b] !== v; k++) @(negedge clk_sys);
    if (k == 40000) begin
      n_fail++;
      print_verdict();
    end
  endtask
  // length of the next high phase in system cycles
  task automatic hi_len(int b);
    wait_at(b, 1'b0);
    wait_at(b, 1'b1);
    for (n = 0; n < 40000 && mon[b] === 1'b1; n++) @(negedge clk_sys);
  endtask
  initial begin
    repeat (95000) @(posedge clk_sys);
    n_fail++;
    print_verdict();
  end
  initial begin
    {arst_n, ctrl_we, te_func_en, rst_req, rst_ext} = 5'h00;
    {n_fail, n_compared} = 0;
    seed = 32'h0000a85a;
    wd = '0;
    gen = bspt_pkg::BSPT_GEN_ONE;
    app = bspt_pkg::BSPT_APP_LTS;
    c = bspt_pkg::bspt_ctrl_t'(xs());
    c.timing_mode = 1'b0;
    start(bspt_pkg::BSPT_GEN_ONE, bspt_pkg::BSPT_APP_LTS);
    hi_len(0);
    check("ssi clock half", n, bspt_pkg::BSPT_SSI_HALF);
    // reset pin held past four clocks; a write inside it is refused
    @(posedge clk_sys);
    rst_ext <= 1'b1;
    repeat (40) @(posedge clk_sys);
    ctrl_we <= 1'b1;
    @(posedge clk_sys);
    ctrl_we <= 1'b0;
    repeat (40) @(posedge clk_sys);
    rst_ext <= 1'b0;
    check("port reset", port_reset, 1'b1);
    // the shared pin must stay low over two ssi half periods
    n = 0;
    repeat (2100) begin
      @(negedge clk_sys);
      n = n | pins.shared_clk;
    end
    check("idle output", n, 0);
    c.timing_mode = 1'b1;
    start(bspt_pkg::BSPT_GEN_ONE, bspt_pkg::BSPT_APP_NT);
    hi_len(0);
    check("delayed sync", n, 8 * FARP);
    // frame restarts follow the far sync: one pulse per far frame
    wait_at(4, 1'b1);
    @(negedge clk_sys);
    for (n = 1; n < 40000 && mon[4] !== 1'b1; n++) @(negedge clk_sys);
    check("frame length", n, bspt_pkg::BSPT_G1_FRAME_DCL * FARP);
    c = bspt_pkg::bspt_ctrl_t'(xs());
    c.data_strobe_two_two = 1'b0;
    start(bspt_pkg::BSPT_GEN_TWO, bspt_pkg::BSPT_APP_LTT);
    hi_len(0);
    check("strobe two", n, 16 * FARP);
    c = bspt_pkg::bspt_ctrl_t'(xs());
    start(bspt_pkg::BSPT_GEN_ONE, bspt_pkg::BSPT_APP_TE);
    hi_len(1);
    check("strobe one", n, 16 * DCLP);
    hi_len(2);
    check("strobe two te", n, 16 * DCLP);
    @(posedge clk_sys);
    te_func_en <= 1'b1;
    @(posedge clk_sys);
    rst_req <= 1'b1;
    @(posedge clk_sys);
    rst_req <= 1'b0;
    hi_len(3);
    check("reset out", n, RSTC);
    @(posedge clk_sys);
    te_func_en <= 1'b0;
    start(bspt_pkg::BSPT_GEN_TWO, bspt_pkg::BSPT_APP_TE);
    hi_len(0);
    check("bit clock half", n, DCLP);
    hi_len(1);
    check("frame sync", n, 32 * DCLP);
    print_verdict();
  end
endmodule // tb_top
